// ---- tb/jbs_monitor.sv ----
`timescale 1ns/10ps
module jbs_monitor #(
   parameter NPIN = 30 // user pin count
) (
   input wire clock, // system clock
   input wire rst_b, // sync reset, active low
   input wire jtag_en, // test port selected
   input wire [3:0] tp_i, // test pin levels
   input wire [3:0] tp_o, // test pin drive
   input wire [3:0] tp_oe, // test pin enables
   input wire [3:0] core_tp_oe, // user test pin enables
   input wire [3:0] core_tp_i, // test pin levels to user
   input wire [NPIN-1:0] pin_oe, // user pin enables
   input wire [NPIN-1:0] pin_pu, // pull-up enables
   input wire prog_busy, // programming mode
   input wire prog_done // complete flag
);
   reg [3:0] lo_n; // cycles with port unselected
   reg [3:0] hi_n; // cycles with port selected
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////
   // saturating counts ride out the sync delay of jtag_en
   always @(posedge clock) begin
      if (!rst_b || jtag_en) lo_n <= 4'h0;
      else if (lo_n != 4'hF) lo_n <= lo_n + 4'h1;
      if (!rst_b || !jtag_en) hi_n <= 4'h0;
      else if (hi_n != 4'hF) hi_n <= hi_n + 4'h1;
   end
   ////////////////////////////////////////////////////////////
   property p_busy_pu;
      $past(prog_busy) && prog_busy |-> pin_oe == 0 && &pin_pu;
   endproperty
   a_busy_pu: assert property (p_busy_pu)
      else $error("pins driven while programming");
   property p_busy_rise;
      $rose(prog_busy) |-> ##[0:2] (pin_oe == 0 && &pin_pu);
   endproperty
   a_busy_rise: assert property (p_busy_rise)
      else $error("pins slow to float");
   property p_pu_idle;
      !prog_busy && !$past(prog_busy) |-> pin_pu == 0;
   endproperty
   a_pu_idle: assert property (p_pu_idle)
      else $error("pull-up outside programming");
   property p_noflag_off;
      !prog_done && !$past(prog_done) |-> pin_oe == 0;
   endproperty
   a_noflag_off: assert property (p_noflag_off)
      else $error("pins driven without flag");
   property p_flag_src;
      $rose(prog_done) |-> $past(prog_busy);
   endproperty
   a_flag_src: assert property (p_flag_src)
      else $error("flag set outside programming");
   property p_test_pins;
      hi_n > 4'h4 |-> tp_oe[2:0] == 3'h0 && core_tp_i == 4'h0;
   endproperty
   a_test_pins: assert property (p_test_pins)
      else $error("test pins leak to user");
   property p_user_pins;
      lo_n > 4'h4 && prog_done |-> tp_oe == $past(core_tp_oe);
   endproperty
   a_user_pins: assert property (p_user_pins)
      else $error("test pins not user pins");
   // serial out may move only a few cycles after a link clock fall
   property p_tdo_edge;
      hi_n > 4'h8 && $changed({tp_o[3], tp_oe[3]}) |-> !$past(tp_i[0], 2)
         && ($past(tp_i[0], 3) || $past(tp_i[0], 4) || $past(tp_i[0], 5));
   endproperty
   a_tdo_edge: assert property (p_tdo_edge)
      else $error("serial out moved off falling edge");
endmodule
bind jbs_port jbs_monitor #(.NPIN(NPIN)) u_mon (
   .clock(clock), .rst_b(rst_b), .jtag_en(jtag_en), .tp_i(tp_i),
   .tp_o(tp_o), .tp_oe(tp_oe), .core_tp_oe(core_tp_oe),
   .core_tp_i(core_tp_i), .pin_oe(pin_oe), .pin_pu(pin_pu),
   .prog_busy(prog_busy), .prog_done(prog_done));

// ---- tb/jbs_tester.sv ----
`timescale 1ns/10ps
module jbs_tester (
   input wire clock, // system clock paces the link
   input wire tdo_w, // resolved serial out wire
   output reg tck, // link clock, still between frames
   output reg tms, // mode select
   output reg tdi // serial in
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // one 160 ns link clock; serial out read at the rise
   task bit1(input m, input b, output q);
      begin
         tms = m;
         tdi = b;
         repeat (4) @(negedge clock);
         q = tdo_w;
         tck = 1'b1;
         repeat (4) @(negedge clock);
         tck = 1'b0;
      end
   endtask
   // five highs reach reset, one low parks in idle
   task reset_tap;
      integer i;
      reg q;
      begin
         for (i = 0; i < 5; i = i + 1)
            bit1(1'b1, 1'b0, q);
         bit1(1'b0, 1'b0, q);
      end
   endtask
   // idle to shift, n bits lsb first, update, back to idle
   task scan(input ir, input integer n, input [31:0] din,
      output [31:0] dout);
      integer i;
      reg q;
      begin
         dout = 32'h0;
         bit1(1'b1, 1'b0, q);
         if (ir) bit1(1'b1, 1'b0, q);
         bit1(1'b0, 1'b0, q);
         bit1(1'b0, 1'b0, q);
         for (i = 0; i < n; i = i + 1) begin
            bit1(i == n - 1, din[i], q);
            dout[i] = q;
         end
         bit1(1'b1, ~din[n-1], q);
         bit1(1'b0, din[n-1], q); // data line toggles after frame
      end
   endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`include "jbs_consts.vh"
module tb_top;
   localparam NP = 4; // few user pins keep scans short
   localparam [31:0] ID = 32'h00005A01; // arbitrary identity value
   reg clock; // system clock
   reg rst_b; // sync reset, active low
   reg jtag_en; // test port select
   reg [3:0] core_tp_o; // user values for test pins
   reg [3:0] core_tp_oe; // user enables for test pins
   reg [NP-1:0] pin_i; // board levels at user pins
   reg [NP-1:0] core_o; // core drive values
   reg [NP-1:0] core_oe; // core enables
   wire tck, tms, tdi; // link lines from tester
   wire [3:0] tp_o, tp_oe, core_tp_i; // test pin side
   wire [NP-1:0] pin_o, pin_oe, pin_pu, core_i; // user pin side
   wire prog_busy, prog_done; // programming status
   wire tdo_w; // serial out wire, pulled up when floating
   wire [3:0] tp_i; // test pin levels
   integer mismatches, checks; // tallies
   reg [31:0] d; // last scan result
   assign tdo_w = tp_oe[3] ? tp_o[3] : 1'b1;
   assign tp_i = {tdo_w, tdi, tms, tck};
   always #10 clock = ~clock;
   jbs_port #(.NPIN(NP), .IDCODE(ID)) DUT (
      .clock(clock), .rst_b(rst_b), .jtag_en(jtag_en), .tp_i(tp_i),
      .tp_o(tp_o), .tp_oe(tp_oe), .core_tp_o(core_tp_o),
      .core_tp_oe(core_tp_oe), .core_tp_i(core_tp_i), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu), .core_o(core_o),
      .core_oe(core_oe), .core_i(core_i), .prog_busy(prog_busy),
      .prog_done(prog_done));
   jbs_tester tst (.clock(clock), .tdo_w(tdo_w), .tck(tck), .tms(tms),
      .tdi(tdi));
   ////////////////////////////////////////////////////////////
   task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task ir(input [3:0] op);
      tst.scan(1'b1, 4, {28'h0, op}, d);
   endtask
   task t_reset;
      begin
         chk("flag", 32'h0, prog_done);
         chk("pin_oe", 32'h0, pin_oe);
         tst.reset_tap;
         ir(`JBS_OP_PDONE); // refused outside programming mode
         chk("ir_cap", `JBS_IR_CAPT, d[3:0]);
         tst.scan(1'b0, 1, 32'h1, d);
         chk("flag", 32'h0, prog_done);
         tst.reset_tap;
         tst.scan(1'b0, 32, 32'h0, d);
         chk("idcode", ID, d);
         ir(`JBS_OP_UCODE);
         tst.scan(1'b0, 32, 32'h0, d);
         chk("ucode", `JBS_UCODE_RST, d);
         $display("test reset done");
      end
   endtask
   task t_bypass;
      integer k;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            ir(k ? 4'hA : `JBS_OP_BYPASS); // unassigned code acts alike
            tst.scan(1'b0, 8, 32'hB5, d);
            chk("bypass", 32'h6A, d);
         end
         $display("test bypass done");
      end
   endtask
   task t_prog;
      begin
         ir(`JBS_OP_PENA);
         tst.scan(1'b0, 1, 32'h0, d);
         chk("busy", 32'h1, prog_busy);
         chk("pin_oe", 32'h0, pin_oe);
         chk("pin_pu", 32'hF, pin_pu);
         ir(`JBS_OP_PADDR);
         tst.scan(1'b0, 6, 32'h3F, d); // user code word
         chk("addr_cap", 32'h0, d);
         ir(`JBS_OP_PDATA);
         tst.scan(1'b0, 32, 32'hA5C30F96, d);
         tst.scan(1'b0, 32, 32'hA5C30F96, d);
         chk("cfg_rd", 32'hA5C30F96, d);
         ir(`JBS_OP_PDONE);
         tst.scan(1'b0, 1, 32'h1, d); // flag written last
         chk("done_cap", 32'h0, d);
         chk("pin_oe", 32'h0, pin_oe);
         ir(`JBS_OP_PDIS);
         tst.scan(1'b0, 1, 32'h0, d);
         chk("flag", 32'h1, prog_done);
         chk("busy", 32'h0, prog_busy);
         chk("pin_oe", core_oe, pin_oe);
         chk("pin_o", core_o, pin_o);
         chk("pin_pu", 32'h0, pin_pu);
         ir(`JBS_OP_UCODE);
         tst.scan(1'b0, 32, 32'h0, d);
         chk("ucode", 32'hA5C30F96, d);
         $display("test prog done");
      end
   endtask
   task t_scan;
      begin
         pin_i = 4'h9;
         ir(`JBS_OP_SAMPLE);
         tst.scan(1'b0, 12, 32'h3A0, d); // preload out A, enables 3
         chk("smp_in", 32'h9, d[3:0]);
         chk("core_i", pin_i, core_i);
         chk("pin_o", core_o, pin_o);
         ir(`JBS_OP_EXTEST);
         chk("ext_o", 32'hA, pin_o);
         chk("ext_oe", 32'h3, pin_oe);
         pin_i = 4'h6;
         tst.scan(1'b0, 12, 32'h3A0, d);
         chk("ext_in", 32'h6, d[3:0]);
         tst.reset_tap;
         chk("pin_o", core_o, pin_o);
         $display("test scan done");
      end
   endtask
   task t_user;
      begin
         jtag_en = 1'b0;
         repeat (8) @(negedge clock);
         chk("tp_oe", 32'h8, tp_oe);
         chk("tp_o3", 32'h1, tp_o[3]);
         chk("tp_in", tp_i, core_tp_i);
         jtag_en = 1'b1;
         repeat (8) @(negedge clock);
         chk("tp_oe", 32'h0, tp_oe);
         chk("tp_in", 32'h0, core_tp_i);
         tst.reset_tap;
         $display("test user done");
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      jtag_en = 1'b1;
      core_tp_o = 4'h8;
      core_tp_oe = 4'h8;
      pin_i = 4'h0;
      core_o = 4'h5;
      core_oe = 4'hC;
      mismatches = 0;
      checks = 0;
      repeat (4) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      t_reset;
      t_bypass;
      t_prog;
      t_scan;
      t_user;
      results;
   end
   // tests need well under a millisecond
   initial begin
      #1000000;
      mismatches = mismatches + 1;
      $display("[FAIL] watchdog expected finish seen hang");
      results;
   end
endmodule

// ---- verilog/jbs_consts.vh ----
`ifndef JBS_CONSTS_VH
`define JBS_CONSTS_VH
// instruction register width and capture pattern
`define JBS_IR_W 4
`define JBS_IR_CAPT 4'h1
// opcodes
`define JBS_OP_EXTEST 4'h0
`define JBS_OP_SAMPLE 4'h1
`define JBS_OP_IDCODE 4'h2
`define JBS_OP_UCODE 4'h3
`define JBS_OP_PENA 4'h4
`define JBS_OP_PADDR 4'h5
`define JBS_OP_PDATA 4'h6
`define JBS_OP_PDONE 4'h7
`define JBS_OP_PDIS 4'h8
`define JBS_OP_BYPASS 4'hF
// test pin positions within the four-pin group
`define JBS_TP_TCK 0
`define JBS_TP_TMS 1
`define JBS_TP_TDI 2
`define JBS_TP_TDO 3
// fixed register lengths
`define JBS_LEN_ID 8'h20
`define JBS_LEN_ONE 8'h01
// reset values
`define JBS_UCODE_RST 32'hFFFFFFFF
`endif

// ---- verilog/jbs_mem.v ----
`timescale 1ns/10ps
module jbs_mem #(
   parameter AW = 6, // address width
   parameter DW = 32 // word width
) (
   input wire clock, // system clock
   input wire we, // write strobe, one cycle
   input wire [AW-1:0] waddr, // write address
   input wire [DW-1:0] wdata, // write data
   input wire [AW-1:0] raddr, // read address
   output reg [DW-1:0] rdata_q // registered read data
);
   // configuration store; contents are not touched by reset
   reg [DW-1:0] mem [0:(1<<AW)-1];

   //////////////////////////////////////////////////////////////////
   // write port and registered read port
   always @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

// ---- verilog/jbs_port.v ----
// Notes on behaviour
// - programming over four-pin serial test port
// - pins float with pull-up while programming
// - done flag last; no drive until set
// - sample captures pin values without disturbance
// - sample preloads pattern for external test
// - external test drives outputs once done flag set and not programming, captures inputs
// - bypass puts one bit between data pins
// - identification code shifts out serially
// - 32-bit user code shifts out serially
// - extra instructions load non-volatile configuration
// - programming flow follows concurrent programming standard
// - test pins become user pins when unused
// - four pins dedicated when test port used
`timescale 1ns/10ps
`include "jbs_consts.vh"
module jbs_port #(
   parameter NPIN = 30, // user i/o pins
   parameter AW = 6, // configuration address width
   parameter DW = 32, // configuration word width
   parameter [31:0] IDCODE = 32'h00001001 // arbitrary value
) (
   input wire clock, // system clock
   input wire rst_b, // sync reset, active low
   input wire jtag_en, // test port in use (pin level)
   input wire [3:0] tp_i, // test pin levels
   output reg [3:0] tp_o, // test pin drive values
   output reg [3:0] tp_oe, // test pin enables
   input wire [3:0] core_tp_o, // user values for test pins
   input wire [3:0] core_tp_oe, // user enables for test pins
   output reg [3:0] core_tp_i, // test pin levels to user
   input wire [NPIN-1:0] pin_i, // user pin levels
   output reg [NPIN-1:0] pin_o, // user pin drive values
   output reg [NPIN-1:0] pin_oe, // user pin enables
   output reg [NPIN-1:0] pin_pu, // weak pull-up enables
   input wire [NPIN-1:0] core_o, // core drive values
   input wire [NPIN-1:0] core_oe, // core enables
   output reg [NPIN-1:0] core_i, // pin levels to core
   output reg prog_busy, // programming mode active
   output reg prog_done // programming complete flag
);
   localparam BSR = 3 * NPIN; // boundary cells: in, out, enable
   localparam SRW = (BSR > DW) ? ((BSR > 32) ? BSR : 32)
                               : ((DW > 32) ? DW : 32);
   localparam IRW = `JBS_IR_W;

   //////////////////////////////////////////////////////////////////
   // input synchronisers
   reg [3:0] tp_s1_q; // first stage, test pins
   reg [3:0] tp_s2_q; // second stage, test pins
   reg tck_s3_q; // delayed tck for edge finding
   reg en_s1_q; // first stage, enable
   reg en_s2_q; // second stage, enable
   reg [NPIN-1:0] pi_s1_q; // first stage, user pins
   reg [NPIN-1:0] pi_s2_q; // second stage, user pins

   always @(posedge clock) begin
      if (!rst_b) begin
         tp_s1_q <= 4'h0;
         tp_s2_q <= 4'h0;
         tck_s3_q <= 1'b0;
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
         pi_s1_q <= {NPIN{1'b0}};
         pi_s2_q <= {NPIN{1'b0}};
      end else begin
         tp_s1_q <= tp_i;
         tp_s2_q <= tp_s1_q;
         tck_s3_q <= tp_s2_q[`JBS_TP_TCK];
         en_s1_q <= jtag_en;
         en_s2_q <= en_s1_q;
         pi_s1_q <= pin_i;
         pi_s2_q <= pi_s1_q;
      end
   end

   // tck edges; test clock must stay slower than a few system clocks
   wire tck = tp_s2_q[`JBS_TP_TCK];
   wire tck_rise = en_s2_q & tck & ~tck_s3_q;
   wire tck_fall = en_s2_q & ~tck & tck_s3_q;
   wire tms = tp_s2_q[`JBS_TP_TMS];
   wire tdi = tp_s2_q[`JBS_TP_TDI];

   //////////////////////////////////////////////////////////////////
   // controller
   wire st_tlr; // test-logic-reset
   wire st_cdr; // capture-dr
   wire st_sdr; // shift-dr
   wire st_udr; // update-dr
   wire st_cir; // capture-ir
   wire st_sir; // shift-ir
   wire st_uir; // update-ir

   jbs_tap u_tap (
      .clock(clock),
      .rst_b(rst_b),
      .hold(~en_s2_q),
      .step(tck_rise),
      .tms(tms),
      .st_tlr(st_tlr),
      .st_cdr(st_cdr),
      .st_sdr(st_sdr),
      .st_udr(st_udr),
      .st_cir(st_cir),
      .st_sir(st_sir),
      .st_uir(st_uir)
   );

   //////////////////////////////////////////////////////////////////
   // data register length per instruction
   function [7:0] dr_len;
      input [IRW-1:0] op;
      begin
         case (op)
            `JBS_OP_EXTEST, `JBS_OP_SAMPLE: dr_len = BSR[7:0];
            `JBS_OP_IDCODE, `JBS_OP_UCODE: dr_len = `JBS_LEN_ID;
            `JBS_OP_PADDR: dr_len = AW[7:0];
            `JBS_OP_PDATA: dr_len = DW[7:0];
            default: dr_len = `JBS_LEN_ONE; // bypass and 1-bit ops
         endcase
      end
   endfunction

   reg [IRW-1:0] ir_q; // active instruction
   reg [IRW-1:0] irs_q; // instruction shift stage
   reg [SRW-1:0] sr_q; // shared data shift register
   reg [BSR-1:0] upd_q; // boundary update latches
   reg [AW-1:0] addr_q; // programming address
   reg [31:0] ucode_q; // user code
   reg isp_q; // programming mode
   reg done_q; // programming complete flag
   reg tdo_q; // serial out value
   reg tdo_oe_q; // serial out enable
   wire [DW-1:0] mem_rd; // configuration read data
   reg [SRW-1:0] cap_v; // capture value
   reg [SRW-1:0] sh_v; // shifted value
   wire [7:0] len = dr_len(ir_q);
   integer i;

   //////////////////////////////////////////////////////////////////
   // capture source per instruction
   always @* begin
      cap_v = {SRW{1'b0}};
      case (ir_q)
         `JBS_OP_EXTEST, `JBS_OP_SAMPLE: begin
            cap_v[BSR-1:0] = {pin_oe, pin_o, pi_s2_q};
         end
         `JBS_OP_IDCODE: cap_v[31:0] = IDCODE;
         `JBS_OP_UCODE: cap_v[31:0] = ucode_q;
         `JBS_OP_PADDR: cap_v[AW-1:0] = addr_q;
         `JBS_OP_PDATA: cap_v[DW-1:0] = mem_rd;
         `JBS_OP_PDONE: cap_v[0] = done_q;
         default: cap_v[0] = 1'b0; // bypass cell
      endcase
   end

   // shift toward bit 0, tdi enters at the top of the active length
   wire [SRW-1:0] sr_dn = sr_q >> 1; // one place down, no index past top
   always @* begin
      sh_v = {SRW{1'b0}};
      for (i = 0; i < SRW; i = i + 1) begin
         if (i == len - 1) begin
            sh_v[i] = tdi;
         end else if (i < len - 1) begin
            sh_v[i] = sr_dn[i];
         end
      end
   end

   // configuration writes only inside programming mode
   wire mem_we = tck_rise & st_udr & isp_q & (ir_q == `JBS_OP_PDATA);

   jbs_mem #(.AW(AW), .DW(DW)) u_mem (
      .clock(clock),
      .we(mem_we),
      .waddr(addr_q),
      .wdata(sr_q[DW-1:0]),
      .raddr(addr_q),
      .rdata_q(mem_rd)
   );

   //////////////////////////////////////////////////////////////////
   // scan actions on the test clock rise
   always @(posedge clock) begin
      if (!rst_b) begin
         ir_q <= `JBS_OP_IDCODE;
         irs_q <= {IRW{1'b0}};
         sr_q <= {SRW{1'b0}};
         upd_q <= {BSR{1'b0}};
         addr_q <= {AW{1'b0}};
         ucode_q <= `JBS_UCODE_RST;
         isp_q <= 1'b0;
         done_q <= 1'b0;
      end else if (tck_rise) begin
         if (st_tlr) begin
            ir_q <= `JBS_OP_IDCODE;
         end
         if (st_cir) begin
            irs_q <= `JBS_IR_CAPT;
         end else if (st_sir) begin
            irs_q <= {tdi, irs_q[IRW-1:1]};
         end else if (st_uir) begin
            ir_q <= irs_q;
         end
         if (st_cdr) begin
            sr_q <= cap_v;
         end else if (st_sdr) begin
            sr_q <= sh_v;
         end else if (st_udr) begin
            case (ir_q)
               `JBS_OP_EXTEST, `JBS_OP_SAMPLE: begin
                  upd_q <= sr_q[BSR-1:0];
               end
               `JBS_OP_PENA: begin
                  isp_q <= 1'b1;
                  done_q <= 1'b0; // flag erased first
               end
               `JBS_OP_PDIS: isp_q <= 1'b0;
               `JBS_OP_PADDR: if (isp_q) addr_q <= sr_q[AW-1:0];
               `JBS_OP_PDATA: begin
                  if (isp_q && (&addr_q)) begin
                     ucode_q <= sr_q[31:0]; // top word is user code
                  end
               end
               `JBS_OP_PDONE: begin
                  if (isp_q) done_q <= sr_q[0]; // last bit written
               end
               default: upd_q <= upd_q; // bypass, idcode: no effect
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // serial out changes on the falling test clock edge
   always @(posedge clock) begin
      if (!rst_b || !en_s2_q) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= st_sir ? irs_q[0] : sr_q[0];
         tdo_oe_q <= st_sir | st_sdr;
      end
   end

   //////////////////////////////////////////////////////////////////
   // user pin drive; programming and blank flag both keep pins off
   always @(posedge clock) begin
      if (!rst_b) begin
         pin_o <= {NPIN{1'b0}};
         pin_oe <= {NPIN{1'b0}};
         pin_pu <= {NPIN{1'b0}};
         core_i <= {NPIN{1'b0}};
         prog_busy <= 1'b0;
         prog_done <= 1'b0;
      end else begin
         core_i <= pi_s2_q; // sampling never disturbs the core
         prog_busy <= isp_q;
         prog_done <= done_q;
         if (isp_q) begin
            pin_o <= {NPIN{1'b0}};
            pin_oe <= {NPIN{1'b0}};
            pin_pu <= {NPIN{1'b1}};
         end else if (!done_q) begin
            pin_o <= {NPIN{1'b0}};
            pin_oe <= {NPIN{1'b0}};
            pin_pu <= {NPIN{1'b0}};
         end else if (ir_q == `JBS_OP_EXTEST) begin
            pin_o <= upd_q[2*NPIN-1:NPIN];
            pin_oe <= upd_q[BSR-1:2*NPIN];
            pin_pu <= {NPIN{1'b0}};
         end else begin
            pin_o <= core_o;
            pin_oe <= core_oe;
            pin_pu <= {NPIN{1'b0}};
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // the four test pins: dedicated port or plain user pins
   always @(posedge clock) begin
      if (!rst_b) begin
         tp_o <= 4'h0;
         tp_oe <= 4'h0;
         core_tp_i <= 4'h0;
      end else if (en_s2_q) begin
         tp_o <= {tdo_q, 3'b000};
         tp_oe <= {tdo_oe_q, 3'b000};
         core_tp_i <= 4'h0;
      end else begin
         tp_o <= core_tp_o;
         tp_oe <= (done_q && !isp_q) ? core_tp_oe : 4'h0;
         core_tp_i <= tp_s2_q;
      end
   end
endmodule

// ---- verilog/jbs_tap.v ----
`timescale 1ns/10ps
module jbs_tap (
   input wire clock, // system clock
   input wire rst_b, // sync reset, active low
   input wire hold, // forces test-logic-reset
   input wire step, // one-cycle pulse per test clock rise
   input wire tms, // synchronised mode select
   output wire st_tlr, // in test-logic-reset
   output wire st_cdr, // in capture-dr
   output wire st_sdr, // in shift-dr
   output wire st_udr, // in update-dr
   output wire st_cir, // in capture-ir
   output wire st_sir, // in shift-ir
   output wire st_uir // in update-ir
);
   // one-hot states of the sixteen-state controller
   localparam TLR = 16'h0001;
   localparam RTI = 16'h0002;
   localparam SDS = 16'h0004;
   localparam CDR = 16'h0008;
   localparam SDR = 16'h0010;
   localparam E1D = 16'h0020;
   localparam PDR = 16'h0040;
   localparam E2D = 16'h0080;
   localparam UDR = 16'h0100;
   localparam SIS = 16'h0200;
   localparam CIR = 16'h0400;
   localparam SIR = 16'h0800;
   localparam E1I = 16'h1000;
   localparam PIR = 16'h2000;
   localparam E2I = 16'h4000;
   localparam UIR = 16'h8000;

   reg [15:0] state_q; // current state
   reg [15:0] state_d; // next state

   //////////////////////////////////////////////////////////////////
   // next state from tms
   always @* begin
      case (state_q)
         TLR: state_d = tms ? TLR : RTI;
         RTI: state_d = tms ? SDS : RTI;
         SDS: state_d = tms ? SIS : CDR;
         CDR: state_d = tms ? E1D : SDR;
         SDR: state_d = tms ? E1D : SDR;
         E1D: state_d = tms ? UDR : PDR;
         PDR: state_d = tms ? E2D : PDR;
         E2D: state_d = tms ? UDR : SDR;
         UDR: state_d = tms ? SDS : RTI;
         SIS: state_d = tms ? TLR : CIR;
         CIR: state_d = tms ? E1I : SIR;
         SIR: state_d = tms ? E1I : SIR;
         E1I: state_d = tms ? UIR : PIR;
         PIR: state_d = tms ? E2I : PIR;
         E2I: state_d = tms ? UIR : SIR;
         UIR: state_d = tms ? SDS : RTI;
         default: state_d = TLR; // illegal code recovers
      endcase
   end

   //////////////////////////////////////////////////////////////////
   // advance only on a test clock rise
   always @(posedge clock) begin
      if (!rst_b || hold) begin
         state_q <= TLR;
      end else if (step) begin
         state_q <= state_d;
      end
   end

   assign st_tlr = state_q == TLR;
   assign st_cdr = state_q == CDR;
   assign st_sdr = state_q == SDR;
   assign st_udr = state_q == UDR;
   assign st_cir = state_q == CIR;
   assign st_sir = state_q == SIR;
   assign st_uir = state_q == UIR;
endmodule
